// ===== hw/sp6_port.sv
// Six-pin port with latches, direction, options, status and interrupt, on AHB-Lite.
// Assumes one clock, pins synchronous to hclk, single-word AHB transfers.
`timescale 1ns/1ps
`include "sp6_map.svh"
module sp6_port
   import sp6_pkg::*;
#(
   parameter bit HAS_SERMEM = 1'b1
) (
   input  wire logic        hclk,        // Bus clock
   input  wire logic        hresetn,     // Power-on reset, active low
   input  wire logic        hsel,        // Slave select
   input  wire logic [31:0] haddr,       // Byte address
   input  wire logic [1:0]  htrans,      // Transfer type
   input  wire logic        hwrite,      // Write when high
   input  wire logic [2:0]  hsize,       // Transfer size
   input  wire logic [31:0] hwdata,      // Write data
   input  wire logic        hready,      // Bus ready
   output logic      [31:0] hrdata,      // Read data
   output logic             hreadyout,   // Slave ready
   output logic             hresp,       // Response
   input  wire logic        rst_req,     // Non-power-up reset pulse
   input  wire sp6_cause_e  rst_cause,   // Cause of that reset
   input  wire logic [5:0]  pin_in,      // Pin levels
   output logic      [5:0]  pin_out,     // Pin drive values
   output logic      [5:0]  pin_oe,      // Pin drive enables
   output logic             ser_clk,     // Serial memory clock
   output logic             ser_dat_out, // Serial memory data, low pulls down
   output logic             ser_dat_oe,  // Serial memory data enable
   input  wire logic        ser_dat_in,  // Serial memory data level
   output logic             irq          // Interrupt level
);

   sp6_req_s    req_q;
   logic [31:0] hrdata_q;
   logic [7:0]  status_q;
   logic [7:0]  latch_q;
   logic [5:0]  dir_q;
   logic [7:0]  opt_q;
   logic [7:0]  irq_st_q;
   logic [7:0]  irq_mask_q;
   logic [5:0]  pin_smp_q;
   logic [5:0]  pin_prev_q;

   // Address phase decode
   wire         ap_take = hsel & hready & htrans[1];
   sp6_req_s    req_d;
   assign req_d = '{wr:  ap_take & hwrite,
                    rd:  ap_take & ~hwrite,
                    idx: haddr[7:2]};

   // Data phase selects
   wire wr_status = req_q.wr & (req_q.idx == `SP6_IDX_STATUS);
   wire wr_port   = req_q.wr & (req_q.idx == `SP6_IDX_PORT);
   wire wr_dir    = req_q.wr & (req_q.idx == `SP6_IDX_DIR);
   wire wr_opt    = req_q.wr & (req_q.idx == `SP6_IDX_OPT);
   wire wr_ist    = req_q.wr & (req_q.idx == `SP6_IDX_IRQ_ST);
   wire wr_imask  = req_q.wr & (req_q.idx == `SP6_IDX_IRQ_MASK);
   wire wr_bitop  = req_q.wr & (req_q.idx == `SP6_IDX_BITOP);

   // Port read value: pin levels, serial bits from latch and line
   wire [1:0] ser_rd  = HAS_SERMEM ? {latch_q[7], latch_q[6] & ser_dat_in} : 2'b00; // R3
   wire [7:0] port_rd = {ser_rd, pin_smp_q};  // R5

   // Bit set or clear: read whole port, change one bit, rewrite all
   wire [2:0] bop_sel = hwdata[2:0];
   wire       bop_val = hwdata[3];
   wire [7:0] bop_one = 8'h01 << bop_sel;
   wire [7:0] rmw_val = bop_val ? (port_rd | bop_one) : (port_rd & ~bop_one); // R4
   wire [7:0] impl_mask = HAS_SERMEM ? 8'hFF : 8'h3F;
   wire [7:0] port_wval = wr_bitop ? rmw_val : hwdata[7:0];
   wire [7:0] latch_d = (port_wval & impl_mask) | (latch_q & ~impl_mask); // R3 R7

   // Read mux, captured at address phase end so data stands in data phase
   wire [5:0] rd_idx = haddr[7:2];
   logic [7:0] rd_val;
   always_comb begin
      case (rd_idx)
         `SP6_IDX_STATUS:   rd_val = status_q;
         `SP6_IDX_PORT:     rd_val = port_rd;   // R5 R10
         `SP6_IDX_IRQ_ST:   rd_val = irq_st_q;
         `SP6_IDX_IRQ_MASK: rd_val = irq_mask_q;
         default:           rd_val = 8'h00;     // R3
      endcase
   end

   // Pin change events on wake-capable input pins
   wire [5:0] pin_chg = (pin_smp_q ^ pin_prev_q) & dir_q & `SP6_WAKE_PINS;
   wire       wake_ev = (|pin_chg) & ~opt_q[`SP6_OPT_NWAKE];
   wire [7:0] irq_set = {6'h00, rst_req, wake_ev};

   // Status: wake flag only from resets; keeps bits on other resets
   logic [7:0] status_d;
   always_comb begin
      status_d = status_q;
      if (wr_status) begin
         status_d = (status_q & ~`SP6_STATUS_WMASK) | (hwdata[7:0] & `SP6_STATUS_WMASK);
      end
      if (rst_req) begin
         status_d = status_q & `SP6_STATUS_KEEP;                   // R2
         status_d[`SP6_WAKE_BIT] = (rst_cause == SP6_CAUSE_WAKE);   // R1
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         req_q      <= '0;
         hrdata_q   <= 32'h0000_0000;
         pin_smp_q  <= 6'h00;
         pin_prev_q <= 6'h00;
      end else begin
         req_q      <= req_d;
         pin_smp_q  <= pin_in;     // R10
         pin_prev_q <= pin_smp_q;
         if (req_d.rd) begin
            hrdata_q <= {24'h000000, rd_val};
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         status_q <= `SP6_STATUS_POR;
      end else begin
         status_q <= status_d;
      end
   end

   // Latches: only whole-port writes change them; serial bits reset high
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         latch_q <= `SP6_PORT_POR;
      end else if (rst_req) begin
         latch_q <= latch_q | `SP6_SER_MASK;  // R12
      end else if (wr_port | wr_bitop) begin
         latch_q <= latch_d;                  // R7 R10
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dir_q <= `SP6_DIR_RST;
         opt_q <= `SP6_OPT_RST;
      end else if (rst_req) begin
         dir_q <= `SP6_DIR_RST;   // R2 R9
         opt_q <= `SP6_OPT_RST;   // R2
      end else begin
         if (wr_dir) dir_q <= hwdata[5:0];
         if (wr_opt) opt_q <= hwdata[7:0];
      end
   end

   // Interrupt status: set beats write-one-to-clear
   wire [7:0] ist_clr = wr_ist ? (hwdata[7:0] & `SP6_IRQ_MASK) : 8'h00;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         irq_st_q   <= 8'h00;
         irq_mask_q <= 8'h00;
      end else begin
         irq_st_q <= (irq_st_q & ~ist_clr) | irq_set;
         if (wr_imask) irq_mask_q <= hwdata[7:0] & `SP6_IRQ_MASK;
      end
   end

   // Effective direction: timer pin source forces input, pin three input only
   logic [5:0] dir_eff;
   always_comb begin
      dir_eff = dir_q;                                              // R9
      dir_eff[`SP6_INONLY_PIN] = 1'b1;
      if (opt_q[`SP6_OPT_TSRC_BIT]) dir_eff[`SP6_TPIN] = 1'b1;      // R11
   end

   assign pin_out     = latch_q[5:0];    // R6
   assign pin_oe      = ~dir_eff;        // R6 R8
   assign ser_clk     = HAS_SERMEM ? latch_q[7] : 1'b1;  // R12
   assign ser_dat_out = 1'b0;
   assign ser_dat_oe  = HAS_SERMEM ? ~latch_q[6] : 1'b0; // R12
   assign irq         = |(irq_st_q & irq_mask_q);
   assign hrdata      = hrdata_q;
   assign hreadyout   = 1'b1;
   assign hresp       = 1'b0;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   a_wake_flag_set: assert property ( // R1
      rst_req && rst_cause == SP6_CAUSE_WAKE |=> status_q[`SP6_WAKE_BIT] ##1
      (status_q[`SP6_WAKE_BIT] || $past(rst_req)))
      else $error("wake flag not set after wake reset");

   a_wake_flag_clr: assert property ( // R1
      rst_req && rst_cause != SP6_CAUSE_WAKE |=> !status_q[`SP6_WAKE_BIT])
      else $error("wake flag not cleared after other reset");

   a_other_reset_vals: assert property ( // R2
      rst_req |=> dir_q == `SP6_DIR_RST && opt_q == `SP6_OPT_RST && !status_q[5])
      else $error("other reset values wrong");

   a_unimpl_read_zero: assert property ( // R3
      req_d.rd |=> hrdata_q[31:8] == 24'h000000 && !hrdata_q[6] ||
      $past(rd_idx) != `SP6_IDX_STATUS)
      else $error("unimplemented bits read nonzero");

   a_rmw_whole_port: assert property ( // R4
      wr_bitop && !rst_req |=> (latch_q & impl_mask) == ($past(rmw_val) & impl_mask))
      else $error("bit operation did not rewrite whole port");

   a_read_pin_level: assert property ( // R5
      req_d.rd && rd_idx == `SP6_IDX_PORT |=> hrdata_q[5:0] == $past(pin_smp_q))
      else $error("port read not pin levels");

   a_latch_hold: assert property ( // R6
      !wr_port && !wr_bitop && !rst_req |=> $stable(latch_q))
      else $error("latch changed without port write");

   a_drive_on_output: assert property ( // R6
      $fell(dir_q[0]) |-> pin_oe[0] && pin_out[0] == latch_q[0])
      else $error("pin not driven from latch on output");

   a_port_write_all: assert property ( // R7
      wr_port && !rst_req |=> latch_q[5:0] == $past(hwdata[5:0]))
      else $error("port write did not update all latches");

   a_dir_reset_input: assert property ( // R9
      $rose(hresetn) |-> (pin_oe == 6'h00) [*2])
      else $error("pins driven after reset");

   a_timer_pin_input: assert property ( // R11
      opt_q[`SP6_OPT_TSRC_BIT] |-> !pin_oe[`SP6_TPIN])
      else $error("timer pin driven while timer source");

   a_sermem_high: assert property ( // R12
      rst_req |=> ser_clk && !ser_dat_oe)
      else $error("serial memory lines not high after reset");

   a_status_wr_mask: assert property ( // R3
      wr_status && !rst_req |=>
      (status_q & ~`SP6_STATUS_WMASK) == ($past(status_q) & ~`SP6_STATUS_WMASK))
      else $error("status bits outside the writable set changed");

   a_wake_bit_hold: assert property ( // R1
      !rst_req |=> $stable(status_q[`SP6_WAKE_BIT]))
      else $error("wake flag changed without a reset");

   a_status_keep: assert property ( // R2
      rst_req |=>
      (status_q & `SP6_STATUS_KEEP) == ($past(status_q) & `SP6_STATUS_KEEP))
      else $error("status low bits not kept on other reset");

   a_latch_keep_other: assert property ( // R2
      rst_req |=> latch_q[5:0] == $past(latch_q[5:0]))
      else $error("pin latches changed on other reset");

   a_latch_ser_reset: assert property ( // R12
      rst_req |=> (latch_q & `SP6_SER_MASK) == `SP6_SER_MASK)
      else $error("serial latch bits not set on other reset");

   a_ser_open_drain: assert property ( // R12
      ser_dat_out == 1'b0)
      else $error("serial data driven high");

   a_pin_out_latch: assert property ( // R6
      pin_out == latch_q[5:0])
      else $error("pin drive value not from latch");

   a_oe_follows_dir: assert property ( // R9
      !opt_q[`SP6_OPT_TSRC_BIT] |->
      pin_oe[5:4] == ~dir_q[5:4] && pin_oe[2:0] == ~dir_q[2:0])
      else $error("pin drive does not follow direction");

   a_pin_three_input: assert property (
      !pin_oe[`SP6_INONLY_PIN])
      else $error("input-only pin driven");

   a_read_wo_zero: assert property ( // R3
      req_d.rd && (rd_idx == `SP6_IDX_DIR || rd_idx == `SP6_IDX_OPT) |=>
      hrdata_q == 32'h0000_0000)
      else $error("write-only register read nonzero");

   a_read_data_hold: assert property (
      !req_d.rd |=> $stable(hrdata_q))
      else $error("read data changed without a read");

   a_bus_okay: assert property (
      hreadyout && !hresp)
      else $error("bus answer not ready and okay");

   a_wake_event_set: assert property (
      wake_ev |=> irq_st_q[`SP6_IRQ_WAKE])
      else $error("wake event not recorded");

   a_wake_input_only: assert property (
      wake_ev |-> (dir_q & `SP6_WAKE_PINS) != 6'h00)
      else $error("wake event with no wake pin as input");

   a_reset_event_set: assert property (
      rst_req |=> irq_st_q[`SP6_IRQ_RST])
      else $error("reset event not recorded");

   a_irq_set_wins: assert property (
      wr_ist && hwdata[`SP6_IRQ_RST] && rst_req |=> irq_st_q[`SP6_IRQ_RST])
      else $error("reset event lost to a same-cycle clear");

   a_irq_w1c: assert property (
      wr_ist && !rst_req && !wake_ev |=> (irq_st_q & $past(ist_clr)) == 8'h00)
      else $error("interrupt status not cleared by write of one");

   a_irq_unused_zero: assert property ( // R3
      irq_st_q[7:2] == 6'h00 && irq_mask_q[7:2] == 6'h00)
      else $error("unimplemented interrupt bits set");

   c_bitop_write:  cover property (wr_bitop ##1 wr_bitop);
   c_wake_reset:   cover property (rst_req && rst_cause == SP6_CAUSE_WAKE);
   c_irq_raised:   cover property ($rose(irq));
   c_port_read:    cover property (req_d.rd && rd_idx == `SP6_IDX_PORT);
   c_other_reset:  cover property (rst_req && rst_cause != SP6_CAUSE_WAKE);

endmodule // sp6_port

// ===== hw/sp6_map.svh
// Register offsets, field positions, reset values for the six-pin port.
// Assumes inclusion from the package and the port module only.
// Function
// R1: Wake reset sets wake flag, others clear
// R2: Pin, watchdog, wake resets use other-reset values
// R3: Unimplemented bits read zero, ignore writes
// R4: Bit set/clear rewrites whole port
// R5: Port read returns pin levels
// R6: Latch holds while input, drives when output
// R7: Port write updates all latches together
// R8: Outside must not fight a driven pin
// R9: Direction resets to ones; one means input
// R10: Write commits late, read samples early
// R11: Timer pin source forces pin two input
// R12: Serial memory bits always outputs, reset one
`ifndef SP6_MAP_SVH
`define SP6_MAP_SVH
`define SP6_IDX_STATUS   6'h03
`define SP6_IDX_PORT     6'h06
`define SP6_IDX_DIR      6'h08
`define SP6_IDX_OPT      6'h09
`define SP6_IDX_IRQ_ST   6'h0A
`define SP6_IDX_IRQ_MASK 6'h0B
`define SP6_IDX_BITOP    6'h0C
`define SP6_STATUS_POR   8'h18
`define SP6_STATUS_WMASK 8'h27
`define SP6_STATUS_KEEP  8'h1F
`define SP6_WAKE_BIT     7
`define SP6_DIR_RST      6'h3F
`define SP6_OPT_RST      8'hFF
`define SP6_OPT_TSRC_BIT 5
`define SP6_OPT_NWAKE    7
`define SP6_PORT_POR     8'hC0
`define SP6_SER_MASK     8'hC0
`define SP6_TPIN         2
`define SP6_INONLY_PIN   3
`define SP6_WAKE_PINS    6'h0B
`define SP6_IRQ_WAKE     0
`define SP6_IRQ_RST      1
`define SP6_IRQ_MASK     8'h03
`endif

// ===== hw/sp6_pkg.sv
// Types shared by the six-pin port.
// Assumes the constants header is on the include path.
`include "sp6_map.svh"
package sp6_pkg;
   typedef enum logic [1:0] {
      SP6_CAUSE_PIN,
      SP6_CAUSE_WDT,
      SP6_CAUSE_WAKE
   } sp6_cause_e;

   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [5:0] idx;
   } sp6_req_s;
endpackage

// ===== dv/sp6_pins.sv
// Outside circuitry on the six port pins and the serial memory data line.
// Assumes the bench supplies the level it wants on pins the port leaves free.
`timescale 1ns/1ps
module sp6_pins (
   input  wire logic [5:0] pin_out,    // Port drive values
   input  wire logic [5:0] pin_oe,     // Port drive enables
   input  wire logic [5:0] ext_val,    // Level applied on undriven pins
   input  wire logic       ser_dat_oe, // Serial data pull-down
   output logic      [5:0] pin_in,     // Resolved pin levels
   output logic            ser_dat_in  // Serial data level
);
   // Outside backs off wherever the port drives
   assign pin_in     = (pin_oe & pin_out) | (~pin_oe & ext_val);
   // Pull-up holds the line high when released
   assign ser_dat_in = ~ser_dat_oe;
endmodule // sp6_pins

// ===== dv/test_six_pin_port_with_latches.sv
// Self-checking bench for the six-pin port, compared with an integer model.
// Assumes the port answers AHB-Lite with zero wait states.
`timescale 1ns/1ps
module test_six_pin_port_with_latches;
   import sp6_pkg::*;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, rst_req = 0;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, r;
   logic [1:0]  htrans = 0;
   logic [2:0]  hsize = 3'h2;
   sp6_cause_e  rst_cause = SP6_CAUSE_PIN;
   logic        hreadyout, hresp, ser_clk, ser_dat_out, ser_dat_oe, ser_dat_in, irq;
   logic [5:0]  pin_in, pin_out, pin_oe, ext = 0;
   int          mismatches = 0, checks = 0;
   int          lat = 8'hC0, dir = 8'h3F, opt = 8'hFF, st = 8'h18, ist = 0, msk = 0;

   sp6_port sp6_port_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .rst_req(rst_req),
      .rst_cause(rst_cause), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
      .ser_clk(ser_clk), .ser_dat_out(ser_dat_out), .ser_dat_oe(ser_dat_oe),
      .ser_dat_in(ser_dat_in), .irq(irq));
   sp6_pins sp6_pins_inst (.pin_out(pin_out), .pin_oe(pin_oe), .ext_val(ext),
      .ser_dat_oe(ser_dat_oe), .pin_in(pin_in), .ser_dat_in(ser_dat_in));

   initial begin
      forever #12.5 hclk = ~hclk;
   end

   function automatic int oe_m();
      return ~dir & 8'h37 & (opt[5] ? 8'h3B : 8'h3F);
   endfunction

   function automatic int port_m();
      int o;
      o = oe_m();
      return (lat & 8'hC0) | (o & lat) | (~o & ext & 8'h3F);
   endfunction

   task automatic end_of_test();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks++;
      if (g !== e) begin
         mismatches++;
         $display("Error %s expected %h seen %h", n, e, g);
      end
   endtask

   task automatic bus(input logic w, input logic [7:0] a, input int d);
      @(posedge hclk);
      hsel   <= 1'b1;
      haddr  <= {24'h0, a};
      htrans <= 2'h2;
      hwrite <= w;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   task automatic wr(input logic [7:0] a, input int d);
      int v;
      v = port_m();
      bus(1'b1, a, d);
      case (a)
         8'h0C: st = (st & 8'hD8) | (d & 8'h27);
         8'h18: lat = d & 8'hFF;
         8'h20: dir = d & 8'h3F;
         8'h24: opt = d & 8'hFF;
         8'h28: ist = ist & ~d;
         8'h2C: msk = d & 3;
         8'h30: lat = d[3] ? v | (1 << (d & 7)) : v & ~(1 << (d & 7));
         default: ;
      endcase
   endtask

   task automatic rd(input logic [7:0] a, input int e);
      bus(1'b0, a, 0);
      chk($sformatf("reg %h", a), e, r);
   endtask

   task automatic pins();
      #1;
      chk("pin_oe", oe_m() & 8'h3F, pin_oe);
      chk("pin_out", lat & 8'h3F, pin_out);
      chk("ser_clk", lat >> 7, ser_clk);
      chk("ser_dat_oe", ((lat >> 6) & 1) ^ 1, ser_dat_oe);
      chk("ser_dat_out", 0, ser_dat_out);
      chk("hresp", 0, hresp);
      chk("irq", (ist & msk) != 0, irq);
   endtask

   initial begin
      void'($urandom(32'h0822BB42));
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      rd(8'h0C, st);
      rd(8'h18, port_m());
      rd(8'h20, 0);
      wr(8'h3C, 8'hFF);
      rd(8'h3C, 0);
      pins();
      $display("reset test done");
      wr(8'h24, 8'hDF);
      wr(8'h18, 0);
      ext <= 6'h38;
      wr(8'h20, 8'h38);
      wr(8'h30, 5);
      wr(8'h30, 4);
      wr(8'h20, 8'h07);
      pins();
      rd(8'h18, port_m());
      $display("read-modify-write test done");
      wr(8'h20, 8'h3F);
      wr(8'h24, 8'h5F);
      wr(8'h28, 3);
      ext <= 6'h39;
      repeat (3) @(posedge hclk);
      ist = ist | 1;
      pins();
      rd(8'h28, ist);
      wr(8'h2C, 1);
      pins();
      wr(8'h28, 1);
      pins();
      $display("interrupt test done");
      for (int c = 0; c < 3; c++) begin
         wr(8'h0C, 8'hFF);
         wr(8'h18, 8'h3F);
         wr(8'h20, 0);
         @(posedge hclk);
         rst_req   <= 1'b1;
         rst_cause <= sp6_cause_e'(c);
         @(posedge hclk);
         rst_req <= 1'b0;
         st  = (c == 2 ? 8'h80 : 0) | (st & 8'h1F);
         dir = 8'h3F;
         opt = 8'hFF;
         lat = lat | 8'hC0;
         ist = ist | 2;
         pins();
         rd(8'h0C, st);
         rd(8'h18, port_m());
      end
      $display("other reset test done");
      wr(8'h24, 8'hDF);
      repeat (8) begin
         ext <= 6'($urandom);
         wr(8'h18, $urandom & 8'hFF);
         wr(8'h20, $urandom & 8'h3F);
         wr(8'h30, $urandom & 8'h0F);
         pins();
         rd(8'h18, port_m());
      end
      $display("random test done");
      end_of_test();
   end

   initial begin
      repeat (20000) @(posedge hclk);
      mismatches++;
      end_of_test();
   end
endmodule // test_six_pin_port_with_latches
